// file: verilog/asc_pkg.sv
/*
  Constants, types and layouts shared by the task file status,
  control and command unit and its command decoder.
  Assumes a single 25 MHz system clock and a synchronous reset.
*/
// How it works
// (R01) Status read clears interrupt; mirror read does not
// (R02) Status bits: busy,ready,fault,seek,request,fixed,0,error
// (R03) Busy locks host out of command register
// (R04) Other status bits meaningless while busy reads one
// (R05) Ready stays low until commands accepted
// (R06) Write fault flag set on write fault
// (R07) Seek complete flag set while ready
// (R08) Transfer request flag while data word needed
// (R09) Corrected error flagged; multi-sector read continues
// (R10) Error summary set, cause in error register
// (R11) Host reissues media commands that ended erroneously
// (R12) Drive control writes accepted even while busy
// (R13) Control: bit2 reset, bit1 mask, bit3 one
// (R14) Soft reset held while reset bit stays one
// (R15) Interrupt only while mask bit is zero
// (R16) Command starts at once with current parameters
// (R17) Host loads parameters before writing command code
// (R18) Decode sector transfer command codes
// (R19) Decode power management command codes
// (R20) Decode identify, features, seek and housekeeping codes
// (R21) Decode security, health, protect, sense, format codes
// (R22) Each command passes only parameters it uses
// (R23) Invalid or unrunnable command aborts with error
// (R24) Registers selected by chip selects plus address
// (R25) Interrupt at completion or block, until status read
// (R26) Busy held through soft reset until reinitialised
package asc_pkg;
    // Register addresses within each chip-select block
    localparam logic [2:0] ADDR_ERROR = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    localparam logic [2:0] ADDR_COMMAND = 3'h7;
    localparam logic [2:0] ADDR_MIRROR = 3'h6;
    localparam logic [2:0] ADDR_DRVCTL = 3'h6;
    // Status bit positions
    localparam int ST_BUSY = 7;
    localparam int ST_READY = 6;
    localparam int ST_WFAULT = 5;
    localparam int ST_SEEK = 4;
    localparam int ST_XFER = 3;
    localparam int ST_FIXED = 2;
    localparam int ST_ERROR = 0;
    localparam logic [7:0] STATUS_RESET = 8'h80;
    // Drive control layout
    localparam int CTL_SRST = 2;
    localparam int CTL_MASK = 1;
    localparam int CTL_ONE = 3;
    localparam logic [7:0] CTL_RESET = 8'h08;
    // Error register layout
    localparam int ERR_ABORT = 2;
    localparam logic [7:0] ERR_RESET = 8'h00;
    // Parameter use mask positions
    localparam int USE_FR = 0;
    localparam int USE_SC = 1;
    localparam int USE_SN = 2;
    localparam int USE_CY = 3;
    localparam int USE_HD = 4;
    // Host pin vector layout after synchronising
    localparam int PIN_WR = 0;
    localparam int PIN_RD = 1;
    localparam int PIN_CSCTL = 2;
    localparam int PIN_CSCMD = 3;
    localparam int PIN_ADDR = 4;
    localparam int PIN_DATA = 7;
    localparam int PIN_W = 15;
    localparam logic [14:0] PIN_IDLE = 15'h7FFF;

    // Command classes
    typedef enum logic [4:0] {
        CL_PIO_RD = 5'h00, CL_PIO_WR = 5'h01, CL_DMA_RD = 5'h02,
        CL_DMA_WR = 5'h03, CL_MUL_RD = 5'h04, CL_MUL_WR = 5'h05,
        CL_VERIFY = 5'h06, CL_WR_VFY = 5'h07, CL_POWER = 5'h08,
        CL_IDENT = 5'h09, CL_FEATURE = 5'h0A, CL_SETMUL = 5'h0B,
        CL_DIAG = 5'h0C, CL_NOP = 5'h0D, CL_FLUSH = 5'h0E,
        CL_ERASE = 5'h0F, CL_INITP = 5'h10, CL_RECAL = 5'h11,
        CL_SEEK = 5'h12, CL_XLATE = 5'h13, CL_BUF_RD = 5'h14,
        CL_BUF_WR = 5'h15, CL_SECURE = 5'h16, CL_HEALTH = 5'h17,
        CL_WPMODE = 5'h18, CL_SENSE = 5'h19, CL_FORMAT = 5'h1A,
        CL_WR_NOER = 5'h1B, CL_INVALID = 5'h1F
    } asc_class_t;

    // Unit state
    typedef enum logic [1:0] {
        S_INIT = 2'b00, S_IDLE = 2'b01, S_EXEC = 2'b10, S_SRST = 2'b11
    } asc_state_t;

    // Parameter registers of the task file
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] count;
        logic [7:0] sector;
        logic [7:0] cylLo;
        logic [7:0] cylHi;
        logic [7:0] driveHead;
    } asc_param_t;

    // Back end report, same clock
    typedef struct packed {
        logic initDone;
        logic opDone;
        logic opFail;
        logic [7:0] failCode;
        logic writeFault;
        logic corrected;
        logic xferReq;
        logic blockDone;
    } asc_be_t;

    // Command issued to the back end
    typedef struct packed {
        logic start;
        logic [7:0] code;
        asc_class_t cls;
        asc_param_t param;
    } asc_cmd_t;
endpackage : asc_pkg

// file: verilog/asc_cmd_decode.sv
/*
  Command code decoder: class, validity and parameter use mask.
  Purely combinational; fed with the written command byte.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_cmd_decode (
    // Command byte
    input wire logic [7:0] code,
    // Decoded result
    output asc_pkg::asc_class_t cls,
    output logic [4:0] useMask,
    output logic valid
);
    // Code to class map
    always_comb begin
        cls = asc_pkg::CL_INVALID;
        casez (code)
            8'h20, 8'h21: cls = asc_pkg::CL_PIO_RD; // [R18]
            8'h30, 8'h31: cls = asc_pkg::CL_PIO_WR; // [R18]
            8'hC8, 8'hC9: cls = asc_pkg::CL_DMA_RD; // [R18]
            8'hCA, 8'hCB: cls = asc_pkg::CL_DMA_WR; // [R18]
            8'hC4: cls = asc_pkg::CL_MUL_RD; // [R18]
            8'hC5: cls = asc_pkg::CL_MUL_WR; // [R18]
            8'h40, 8'h41: cls = asc_pkg::CL_VERIFY; // [R18]
            8'h3C: cls = asc_pkg::CL_WR_VFY; // [R18]
            8'hE5, 8'h98, 8'hE3, 8'h97, 8'hE1, 8'h95,
            8'hE2, 8'h96, 8'hE0, 8'h94, 8'hE6, 8'h99:
                cls = asc_pkg::CL_POWER; // [R19]
            8'hEC: cls = asc_pkg::CL_IDENT; // [R20]
            8'hEF: cls = asc_pkg::CL_FEATURE; // [R20]
            8'hC6: cls = asc_pkg::CL_SETMUL; // [R20]
            8'h90: cls = asc_pkg::CL_DIAG; // [R20]
            8'h00: cls = asc_pkg::CL_NOP; // [R20]
            8'hE7: cls = asc_pkg::CL_FLUSH; // [R20]
            8'hC0: cls = asc_pkg::CL_ERASE; // [R20]
            8'h91: cls = asc_pkg::CL_INITP; // [R20]
            8'h1?: cls = asc_pkg::CL_RECAL; // [R20]
            8'h7?: cls = asc_pkg::CL_SEEK; // [R20]
            8'h87: cls = asc_pkg::CL_XLATE; // [R20]
            8'hE4: cls = asc_pkg::CL_BUF_RD; // [R20]
            8'hE8: cls = asc_pkg::CL_BUF_WR; // [R20]
            8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6:
                cls = asc_pkg::CL_SECURE; // [R21]
            8'hB0: cls = asc_pkg::CL_HEALTH; // [R21]
            8'h8B: cls = asc_pkg::CL_WPMODE; // [R21]
            8'h03: cls = asc_pkg::CL_SENSE; // [R21]
            8'h50: cls = asc_pkg::CL_FORMAT; // [R21]
            8'h38, 8'hCD: cls = asc_pkg::CL_WR_NOER; // [R21]
            default: cls = asc_pkg::CL_INVALID;
        endcase
    end

    // Which parameter registers each class takes
    always_comb begin
        case (cls)
            asc_pkg::CL_FEATURE, asc_pkg::CL_WPMODE: useMask = 5'h01; // [R22]
            asc_pkg::CL_HEALTH: useMask = 5'h0F; // [R22]
            asc_pkg::CL_SETMUL: useMask = 5'h02; // [R22]
            asc_pkg::CL_INITP: useMask = 5'h12; // [R22]
            asc_pkg::CL_SEEK: useMask = 5'h1C; // [R22]
            asc_pkg::CL_FORMAT: useMask = 5'h1A; // [R22]
            asc_pkg::CL_POWER: useMask = (code == 8'hE3 || code == 8'h97) ? 5'h02 : 5'h00;
            asc_pkg::CL_PIO_RD, asc_pkg::CL_PIO_WR, asc_pkg::CL_DMA_RD,
            asc_pkg::CL_DMA_WR, asc_pkg::CL_MUL_RD, asc_pkg::CL_MUL_WR,
            asc_pkg::CL_VERIFY, asc_pkg::CL_WR_VFY, asc_pkg::CL_ERASE,
            asc_pkg::CL_XLATE, asc_pkg::CL_WR_NOER: useMask = 5'h1E; // [R22]
            default: useMask = 5'h00;
        endcase
    end

    assign valid = (cls != asc_pkg::CL_INVALID); // [R23]
endmodule : asc_cmd_decode
`default_nettype wire

// file: verilog/asc_task_unit.sv
/*
  Host facing status, drive control and command registers.
  Assumes host pins are asynchronous to mclk, parameter registers
  live next door, and a back end executes commands on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_task_unit (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Host pins, asynchronous
    input wire logic csCmdN,
    input wire logic csCtlN,
    input wire logic [2:0] addr,
    input wire logic iordN,
    input wire logic iowrN,
    input wire logic [7:0] dataIn,
    // Host read data and interrupt
    output logic [7:0] dataOut,
    output logic dataOe,
    output logic intrq,
    // Parameter registers, same clock
    input wire asc_pkg::asc_param_t taskParam,
    // Back end
    input wire asc_pkg::asc_be_t beStat,
    output asc_pkg::asc_cmd_t cmdOut,
    output logic hostLock
);
    // Synchroniser stages
    logic [asc_pkg::PIN_W-1:0] pinRaw;
    logic [asc_pkg::PIN_W-1:0] s1_q;
    logic [asc_pkg::PIN_W-1:0] s2_q;
    logic [asc_pkg::PIN_W-1:0] s3_q;
    // Decoded host cycles
    logic rdStart, wrEnd;
    logic rCmdBlk, rCtlBlk, wCmdBlk, wCtlBlk;
    logic [2:0] rAddr, wAddr;
    logic [7:0] wData;
    logic wrCmd, wrCtl, rdStatus, rdMirror, rdError, rdSel;
    // Decoder results
    asc_pkg::asc_class_t decCls;
    logic [4:0] decUse;
    logic decValid;
    // Registers
    asc_pkg::asc_state_t state_q, state_d;
    logic [7:0] ctl_q, ctl_d;
    logic [7:0] err_q, err_d;
    logic errFlag_q, errFlag_d;
    logic ready_q, ready_d;
    logic wfault_q, wfault_d;
    logic fixed_q, fixed_d;
    logic pend_q, pend_d;
    logic intrq_q, dataOe_q, hostLock_q;
    logic [7:0] dataOut_q;
    asc_pkg::asc_cmd_t cmd_q, cmd_d;
    // Status terms
    logic busy, xferNeed, swRst, irqMasked;
    logic cmdAccept, cmdAbort, irqEvt;
    logic [7:0] statusVal, rdVal;
    asc_pkg::asc_param_t passParam;

    // Pin vector in the package layout
    assign pinRaw = {dataIn, addr, csCmdN, csCtlN, iordN, iowrN};

    // Two flops per pin, third stage for edge detection and the write side block, address and data
    generate
        for (genvar i = 0; i < asc_pkg::PIN_W; i++) begin : g_sync
            always_ff @(posedge mclk) begin
                if (srst) begin
                    s1_q[i] <= asc_pkg::PIN_IDLE[i];
                    s2_q[i] <= asc_pkg::PIN_IDLE[i];
                    s3_q[i] <= asc_pkg::PIN_IDLE[i];
                end else begin
                    s1_q[i] <= pinRaw[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                end
            end
        end
    endgenerate

    // Read starts on strobe fall, write lands on strobe rise
    assign rdStart = !s2_q[asc_pkg::PIN_RD] && s3_q[asc_pkg::PIN_RD];
    assign wrEnd = s2_q[asc_pkg::PIN_WR] && !s3_q[asc_pkg::PIN_WR];

    // Block select from chip selects, read side
    assign rCmdBlk = !s2_q[asc_pkg::PIN_CSCMD] && s2_q[asc_pkg::PIN_CSCTL]; // [R24]
    assign rCtlBlk = s2_q[asc_pkg::PIN_CSCMD] && !s2_q[asc_pkg::PIN_CSCTL]; // [R24]
    assign rAddr = s2_q[asc_pkg::PIN_ADDR +: 3];

    // Write side uses values held through the strobe
    assign wCmdBlk = !s3_q[asc_pkg::PIN_CSCMD] && s3_q[asc_pkg::PIN_CSCTL]; // [R24]
    assign wCtlBlk = s3_q[asc_pkg::PIN_CSCMD] && !s3_q[asc_pkg::PIN_CSCTL]; // [R24]
    assign wAddr = s3_q[asc_pkg::PIN_ADDR +: 3];
    assign wData = s3_q[asc_pkg::PIN_DATA +: 8];

    // Register strobes
    assign wrCmd = wrEnd && wCmdBlk && (wAddr == asc_pkg::ADDR_COMMAND);
    assign wrCtl = wrEnd && wCtlBlk && (wAddr == asc_pkg::ADDR_DRVCTL); // [R12]
    assign rdStatus = rdStart && rCmdBlk && (rAddr == asc_pkg::ADDR_STATUS);
    assign rdMirror = rCtlBlk && (rAddr == asc_pkg::ADDR_MIRROR);
    assign rdError = rCmdBlk && (rAddr == asc_pkg::ADDR_ERROR);
    assign rdSel = !s2_q[asc_pkg::PIN_RD] && (rdMirror || rdError ||
                   (rCmdBlk && (rAddr == asc_pkg::ADDR_STATUS)));

    // Command decoder
    asc_cmd_decode u_decode (
        .code(wData),
        .cls(decCls),
        .useMask(decUse),
        .valid(decValid)
    );

    // Control bits
    assign swRst = ctl_q[asc_pkg::CTL_SRST];
    assign irqMasked = ctl_q[asc_pkg::CTL_MASK];

    // Busy unless idle or waiting on the host for data
    assign xferNeed = (state_q == asc_pkg::S_EXEC) && beStat.xferReq; // [R08]
    assign busy = (state_q != asc_pkg::S_IDLE) && !xferNeed; // [R03] [R26]

    // Status byte; flags below busy are not trusted by the host then
    assign statusVal[asc_pkg::ST_BUSY] = busy; // [R02] [R04]
    assign statusVal[asc_pkg::ST_READY] = ready_q; // [R05]
    assign statusVal[asc_pkg::ST_WFAULT] = wfault_q; // [R06]
    assign statusVal[asc_pkg::ST_SEEK] = ready_q && !busy; // [R07]
    assign statusVal[asc_pkg::ST_XFER] = xferNeed; // [R08]
    assign statusVal[asc_pkg::ST_FIXED] = fixed_q; // [R09]
    assign statusVal[1] = 1'b0; // [R02]
    assign statusVal[asc_pkg::ST_ERROR] = errFlag_q; // [R10]

    // Read data mux
    assign rdVal = rdError ? err_q : statusVal; // [R01]

    // Command hand-off decisions, refused while busy
    assign cmdAccept = wrCmd && (state_q == asc_pkg::S_IDLE) && !swRst &&
                       decValid && ready_q && !wfault_q; // [R03] [R16]
    assign cmdAbort = wrCmd && (state_q == asc_pkg::S_IDLE) && !swRst &&
                      !(decValid && ready_q && !wfault_q); // [R23]

    // Interrupt causes: completion, abort, block boundary
    assign irqEvt = cmdAbort || ((state_q == asc_pkg::S_EXEC) &&
                    (beStat.opDone || beStat.blockDone)); // [R25]

    // Unused parameter registers pass as zero; drive/head keeps its upper nibble
    assign passParam.feature = decUse[asc_pkg::USE_FR] ? taskParam.feature : 8'h00; // [R22]
    assign passParam.count = decUse[asc_pkg::USE_SC] ? taskParam.count : 8'h00; // [R22]
    assign passParam.sector = decUse[asc_pkg::USE_SN] ? taskParam.sector : 8'h00; // [R22]
    assign passParam.cylLo = decUse[asc_pkg::USE_CY] ? taskParam.cylLo : 8'h00; // [R22]
    assign passParam.cylHi = decUse[asc_pkg::USE_CY] ? taskParam.cylHi : 8'h00; // [R22]
    assign passParam.driveHead = decUse[asc_pkg::USE_HD] ? taskParam.driveHead :
                                 {taskParam.driveHead[7:4], 4'h0}; // [R22]

    // Drive control: written at any time, reset forces mask clear
    always_comb begin
        ctl_d = ctl_q;
        if (wrCtl) begin
            ctl_d = 8'h00;
            ctl_d[asc_pkg::CTL_ONE] = 1'b1; // [R13]
            ctl_d[asc_pkg::CTL_SRST] = wData[asc_pkg::CTL_SRST]; // [R13] [R14]
            ctl_d[asc_pkg::CTL_MASK] = wData[asc_pkg::CTL_MASK] &&
                                       !wData[asc_pkg::CTL_SRST]; // [R15]
        end
    end

    // Unit sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            asc_pkg::S_INIT: begin
                if (beStat.initDone) begin
                    state_d = asc_pkg::S_IDLE; // [R26]
                end
            end
            asc_pkg::S_IDLE: begin
                if (cmdAccept) begin
                    state_d = asc_pkg::S_EXEC; // [R16]
                end
            end
            asc_pkg::S_EXEC: begin
                if (beStat.opDone) begin
                    state_d = asc_pkg::S_IDLE; // [R09]
                end
            end
            asc_pkg::S_SRST: begin
                if (!swRst) begin
                    state_d = asc_pkg::S_INIT; // [R14] [R26]
                end
            end
            default: state_d = asc_pkg::S_INIT;
        endcase
        if (swRst) begin
            state_d = asc_pkg::S_SRST; // [R14]
        end
    end

    // Ready: low through init and soft reset
    always_comb begin
        ready_d = ready_q;
        if (swRst || state_q == asc_pkg::S_SRST) begin
            ready_d = 1'b0; // [R05]
        end else if (state_q == asc_pkg::S_INIT && beStat.initDone) begin
            ready_d = 1'b1; // [R05] [R26]
        end
    end

    // Error summary and error register
    always_comb begin
        errFlag_d = errFlag_q;
        err_d = err_q;
        if (swRst) begin
            errFlag_d = 1'b0;
            err_d = asc_pkg::ERR_RESET;
        end else if (cmdAbort) begin
            errFlag_d = 1'b1; // [R23]
            err_d = asc_pkg::ERR_RESET;
            err_d[asc_pkg::ERR_ABORT] = 1'b1; // [R23]
        end else if (cmdAccept) begin
            errFlag_d = 1'b0;
            err_d = asc_pkg::ERR_RESET;
        end else if (state_q == asc_pkg::S_EXEC && beStat.opDone) begin
            errFlag_d = beStat.opFail; // [R10]
            err_d = beStat.opFail ? beStat.failCode : asc_pkg::ERR_RESET; // [R10]
        end
    end

    // Fault and corrected flags, event wins over clear, but soft reset beats write fault
    always_comb begin
        wfault_d = wfault_q;
        fixed_d = fixed_q;
        if (swRst || cmdAccept) begin
            wfault_d = 1'b0;
            fixed_d = 1'b0;
        end
        if (beStat.writeFault && !swRst) begin
            wfault_d = 1'b1; // [R06]
        end
        if (beStat.corrected && state_q == asc_pkg::S_EXEC) begin
            fixed_d = 1'b1; // [R09]
        end
    end

    // Pending interrupt: set wins over status read clear
    always_comb begin
        pend_d = pend_q;
        if (rdStatus || swRst) begin
            pend_d = 1'b0; // [R01]
        end
        if (irqEvt && !irqMasked && !swRst) begin
            pend_d = 1'b1; // [R25] [R15]
        end
    end

    // Command to the back end, one cycle start pulse
    always_comb begin
        cmd_d = cmd_q;
        cmd_d.start = 1'b0;
        if (cmdAccept) begin
            cmd_d.start = 1'b1; // [R16]
            cmd_d.code = wData;
            cmd_d.cls = decCls;
            cmd_d.param = passParam; // [R16] [R22]
        end
    end

    // State registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= asc_pkg::S_INIT;
            ctl_q <= asc_pkg::CTL_RESET; // [R13] [R15]
            ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            ctl_q <= ctl_d;
            ready_q <= ready_d;
        end
    end

    // Flag registers
    always_ff @(posedge mclk) begin
        if (srst) begin
            err_q <= asc_pkg::ERR_RESET;
            errFlag_q <= 1'b0;
            wfault_q <= 1'b0;
            fixed_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            err_q <= err_d;
            errFlag_q <= errFlag_d;
            wfault_q <= wfault_d;
            fixed_q <= fixed_d;
            pend_q <= pend_d;
        end
    end

    // Registered outputs
    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_q <= '0;
            intrq_q <= 1'b0;
            dataOe_q <= 1'b0;
            dataOut_q <= asc_pkg::STATUS_RESET; // [R02]
            hostLock_q <= 1'b1;
        end else begin
            cmd_q <= cmd_d;
            intrq_q <= pend_d && !ctl_d[asc_pkg::CTL_MASK]; // [R15]
            dataOe_q <= rdSel;
            if (rdStart) begin
                dataOut_q <= rdVal; // [R01]
            end
            hostLock_q <= (state_d != asc_pkg::S_IDLE) &&
                          !(state_d == asc_pkg::S_EXEC && beStat.xferReq); // [R03]
        end
    end

    assign dataOut = dataOut_q;
    assign dataOe = dataOe_q;
    assign intrq = intrq_q;
    assign cmdOut = cmd_q;
    assign hostLock = hostLock_q;
endmodule : asc_task_unit
`default_nettype wire

// file: dv/asc_task_monitor.sv
/* Port checker for the task unit.
   Assumes one mclk domain, srst synchronous high. */
`timescale 1ns/1ps
`default_nettype none
module asc_task_monitor (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Host pins
    input wire logic csCmdN,
    input wire logic csCtlN,
    input wire logic [2:0] addr,
    input wire logic iordN,
    input wire logic [7:0] dataOut,
    input wire logic dataOe,
    input wire logic intrq,
    // Back end
    input wire asc_pkg::asc_be_t beStat,
    input wire asc_pkg::asc_cmd_t cmdOut,
    input wire logic hostLock
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Reset values
    reset_vals_a: assert property (disable iff (1'b0) srst |=> hostLock && !intrq && !dataOe
        && dataOut == 8'h80 && !cmdOut.start) else $error("reset values");
    start_pulse_a: assert property (cmdOut.start |=> (!cmdOut.start && $stable(cmdOut.code)) [*3])
        else $error("start pulse");
    start_lock_a: assert property (cmdOut.start |-> hostLock && !$past(hostLock))
        else $error("start lock");
    lock_fall_a: assert property ($fell(hostLock) |-> $past(beStat.initDone || beStat.opDone || beStat.xferReq))
        else $error("lock fall");
    read_oe_a: assert property ($rose(dataOe) |-> !$past(iordN, 2))
        else $error("read enable");
    status_clear_a: assert property ($rose(dataOe) && !csCmdN && addr == 3'h7
        && !$past(beStat.opDone || beStat.blockDone) |-> !intrq) else $error("status clear");
    mirror_keep_a: assert property ($rose(dataOe) && !csCtlN && addr == 3'h6 && $past(intrq) |-> intrq)
        else $error("mirror clear");
    feature_use_a: assert property (cmdOut.start && cmdOut.param.feature != 8'h00 |-> cmdOut.cls inside
        {asc_pkg::CL_FEATURE, asc_pkg::CL_HEALTH, asc_pkg::CL_WPMODE}) else $error("feature passed");
endmodule : asc_task_monitor
bind asc_task_unit asc_task_monitor u_asc_task_monitor (.*);
`default_nettype wire

// file: dv/asc_be_model.sv
/* Back end model: init and command completion pulses.
   Assumes the bench asks for init, failure and slow runs. */
`timescale 1ns/1ps
`default_nettype none
module asc_be_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Bench controls
    input wire logic initReq,
    input wire logic failReq,
    input wire logic slowReq,
    // Unit side
    input wire asc_pkg::asc_cmd_t cmd,
    output var asc_pkg::asc_be_t beStat
);
    int initCnt, opCnt;
    // One-cycle pulses
    always @(posedge mclk) begin
        beStat <= '0;
        if (srst) begin
            initCnt <= 0;
            opCnt <= 0;
        end else begin
            initCnt <= initReq ? 5 : (initCnt > 0 ? initCnt - 1 : 0);
            beStat.initDone <= (initCnt == 1);
            beStat.blockDone <= (opCnt == 3);
            opCnt <= cmd.start ? (slowReq ? 80 : 6) : (opCnt > 0 ? opCnt - 1 : 0);
            if (opCnt == 1) begin
                beStat.opDone <= 1'b1;
                beStat.opFail <= failReq;
                beStat.failCode <= failReq ? 8'h10 : 8'h00;
                beStat.writeFault <= failReq;
            end
        end
    end
endmodule : asc_be_model
`default_nettype wire

// file: dv/asc_task_unit_tb.sv
/* Self-checking bench for the task unit.
   Assumes the back end model and bound checker. */
`timescale 1ns/1ps
`default_nettype none
module asc_task_unit_tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic csCmdN = 1'b1, csCtlN = 1'b1, iordN = 1'b1, iowrN = 1'b1;
    logic [2:0] addr = 3'h0;
    logic [7:0] dataIn = 8'h00, dataOut;
    logic dataOe, intrq, hostLock;
    logic initReq = 1'b0, failReq = 1'b0, slowReq = 1'b0;
    asc_pkg::asc_param_t taskParam = '0;
    asc_pkg::asc_be_t beStat;
    asc_pkg::asc_cmd_t cmdOut, gotCmd;
    int num_errors = 0, n_tests = 0, starts = 0, base;
    // Codes in class order, then the alternate codes
    logic [0:49][7:0] codes = {200'h2030C8CAC4C5403CE5ECEFC69000E7C091107087E4E8F1B08B,
        200'h0350382131C9CB4198E397E195E296E094E699F2F3F4F5F6CD};
    asc_task_unit u_asc_task_unit (.*);
    asc_be_model u_asc_be_model (.mclk, .srst, .initReq, .failReq, .slowReq, .cmd(cmdOut), .beStat);
    initial forever #20 mclk = ~mclk;
    // Capture each command
    always @(posedge mclk) begin
        if (cmdOut.start === 1'b1) begin
            gotCmd <= cmdOut;
            starts <= starts + 1;
        end
    end
    function automatic int clsOf(input int i);
        return i < 28 ? i : i < 32 ? i - 28 : i == 32 ? 6 : i < 44 ? 8 : i < 49 ? 22 : 27;
    endfunction : clsOf
    // Used: feature, count, sector, cylinder, full head
    function automatic logic [4:0] useOf(input int c, input logic [7:0] k);
        case (c)
            0, 1, 2, 3, 4, 5, 6, 7, 15, 19, 27: return 5'b01111;
            26: return 5'b01011;
            18: return 5'b00111;
            10, 24: return 5'b10000;
            23: return 5'b11110;
            11: return 5'b01000;
            16: return 5'b01001;
            8: return (k == 8'hE3 || k == 8'h97) ? 5'b01000 : 5'b00000;
            default: return 5'b00000;
        endcase
    endfunction : useOf
    function automatic asc_pkg::asc_param_t expP(input logic [4:0] u, input asc_pkg::asc_param_t p);
        return p & {{8{u[4]}}, {8{u[3]}}, {8{u[2]}}, {16{u[1]}}, 4'hF, {4{u[0]}}};
    endfunction : expP
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Register write, strobe and gap 4 cycles
    task automatic hw(input logic ctl, input logic [2:0] a, input logic [7:0] d);
        @(negedge mclk);
        {csCmdN, csCtlN, addr, dataIn, iowrN} = {ctl, !ctl, a, d, 1'b0};
        repeat (4) @(negedge mclk);
        iowrN = 1'b1;
        repeat (4) @(negedge mclk);
        {csCmdN, csCtlN, addr, dataIn} = {2'b11, ~a, ~d};
    endtask : hw
    task automatic hr(input string nm, input logic ctl, input logic [2:0] a, input logic [7:0] e,
        input logic [7:0] m = 8'hFF, input logic oe = 1'b1);
        @(negedge mclk);
        {csCmdN, csCtlN, addr, iordN} = {ctl, !ctl, a, 1'b0};
        repeat (5) @(negedge mclk);
        chk("oe", oe, dataOe);
        if (oe) chk(nm, e, dataOut & m);
        iordN = 1'b1;
        repeat (4) @(negedge mclk);
        {csCmdN, csCtlN, addr} = {2'b11, ~a};
    endtask : hr
    // Command, then mirror and status reads
    task automatic cmd(input logic [7:0] k, input int c, input logic [7:0] st, input logic ie);
        base = starts;
        taskParam = 48'({$urandom(), $urandom()});
        hw(1'b0, 3'h7, k);
        repeat (300) if (hostLock === 1'b1) @(negedge mclk);
        chk("starts", base + (c >= 0), starts);
        if (c >= 0) begin
            chk("code", k, gotCmd.code);
            chk("class", c, gotCmd.cls);
            chk("param", expP(useOf(c, k), taskParam), gotCmd.param);
        end
        hr("mirror", 1'b1, 3'h6, st);
        chk("irq", ie, intrq);
        hr("status", 1'b0, 3'h7, st);
        chk("irq cleared", 1'b0, intrq);
    endtask : cmd
    task automatic give_verdict();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    initial begin
        #(40 * 20000);
        num_errors++;
        give_verdict();
    end
    initial begin
        void'($urandom(32'h3C399D37));
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        hr("reset", 1'b0, 3'h7, 8'h80);
        hr("error", 1'b0, 3'h1, 8'h00);
        hr("unmapped", 1'b1, 3'h0, 8'h00, 8'h00, 1'b0);
        initReq = 1'b1;
        @(negedge mclk);
        initReq = 1'b0;
        repeat (10) @(negedge mclk);
        for (int i = 0; i < 50; i++)
            cmd(codes[i] | 8'((i == 17 || i == 18) ? $urandom() % 16 : 0), clsOf(i), 8'h50, 1'b1);
        cmd(8'hFF, -1, 8'h51, 1'b1);
        hr("abort cause", 1'b0, 3'h1, 8'h04);
        // Busy: command refused, control write taken
        slowReq = 1'b1;
        base = starts;
        hw(1'b0, 3'h7, 8'hEC);
        hw(1'b0, 3'h7, 8'hE7);
        hw(1'b1, 3'h6, 8'h0A);
        hr("busy", 1'b1, 3'h6, 8'h80, 8'h80);
        slowReq = 1'b0;
        repeat (300) if (hostLock === 1'b1) @(negedge mclk);
        chk("refused", base + 1, starts);
        chk("masked irq", 1'b0, intrq);
        failReq = 1'b1;
        cmd(8'h30, 1, 8'h71, 1'b0);
        failReq = 1'b0;
        hr("fail cause", 1'b0, 3'h1, 8'h10);
        cmd(8'h20, -1, 8'h71, 1'b0);
        hw(1'b1, 3'h6, 8'h0C);
        hr("in reset", 1'b1, 3'h6, 8'h80, 8'hC0);
        hw(1'b1, 3'h6, 8'h08);
        hr("reinit", 1'b1, 3'h6, 8'h80, 8'hC0);
        initReq = 1'b1;
        @(negedge mclk);
        initReq = 1'b0;
        repeat (10) @(negedge mclk);
        cmd(8'h30, 1, 8'h50, 1'b1);
        hw(1'b1, 3'h6, 8'hF8);
        cmd(8'h00, 13, 8'h50, 1'b1);
        give_verdict();
    end
endmodule : asc_task_unit_tb
`default_nettype wire
